//--- design/apub_top.sv
// Operation
// RULE1 - Commit-current command activates all pending values of selected axis unconditionally.
// RULE2 - Masked commit activates pending values of every masked axis together.
// RULE3 - Auto commit per axis is off at reset; enable and disable commands.
// RULE4 - Auto commit enable readable as a bit of the axis mode register.
// RULE5 - A fired breakpoint disarms itself; host must arm again for more.
// RULE6 - Disarm command before firing cancels trigger and auto commit.
// RULE7 - Four conditions: rising position, falling position, motion done, home capture.
// RULE8 - Rising condition fires when actual position >= active threshold.
// RULE9 - Falling condition fires when actual position <= active threshold.
// RULE10 - Host commits threshold before arming a position condition.
// RULE11 - Threshold read returns the held threshold of the selected axis.
// RULE12 - Motion done condition fires when motion complete flag is one.
// RULE13 - On firing clear arming, then commit pending values if auto enabled.
// RULE14 - On firing set the triggered flag regardless of auto commit.
// RULE15 - Smooth halt stays pending until committed by command or auto commit.
// RULE16 - Home condition fires when capture requested and captured flag is one.
// RULE17 - Commits copy pending to active at next sample tick, all together.
// RULE18 - Conditions checked once per sample tick, one trigger per arming.
module apub_top (
    input  wire logic                           CORE_CLK_I,
    input  wire logic                           NRST_I,
    input  wire logic                           PSEL_I,
    input  wire logic                           PENABLE_I,
    input  wire logic                           PWRITE_I,
    input  wire logic [apub_pkg::AW-1:0]        PADDR_I,
    input  wire logic [apub_pkg::DW-1:0]        PWDATA_I,
    output logic      [apub_pkg::DW-1:0]        PRDATA_O,
    output logic                                PREADY_O,
    output logic                                PSLVERR_O,
    input  wire logic [apub_pkg::NUM_AXES*32-1:0] POS_ACT_I,
    input  wire logic [apub_pkg::NUM_AXES-1:0]  MOTION_DONE_I,
    input  wire logic [apub_pkg::NUM_AXES-1:0]  HOME_REQ_I,
    input  wire logic [apub_pkg::NUM_AXES-1:0]  HOME_CAPT_I,
    output logic      [apub_pkg::NUM_AXES*32-1:0] VEL_ACT_O,
    output logic      [apub_pkg::NUM_AXES-1:0]  SMOOTH_HALT_O,
    output logic      [apub_pkg::NUM_AXES-1:0]  BRK_FIRED_O,
    output logic                                SAMPLE_TICK_O,
    output logic                                IRQ_O
);

    localparam int N = apub_pkg::NUM_AXES;

    ////////////////////////////////////////////////////////////////////////
    // Sample period divider

    logic [apub_pkg::SCW-1:0] smp_cnt_r;
    logic                     tick_r;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            smp_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else if (smp_cnt_r == apub_pkg::SCW'(apub_pkg::SAMPLE_CYC - 1)) begin
            smp_cnt_r <= '0;
            tick_r    <= 1'b1;
        end else begin
            smp_cnt_r <= smp_cnt_r + 1'b1;
            tick_r    <= 1'b0;
        end
    end

    assign SAMPLE_TICK_O = tick_r;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic                     addr_ok;
    logic                     wr_en;
    logic                     rd_setup;
    logic [apub_pkg::AXW-1:0] axis_r;
    logic [N-1:0]             sel_cur;

    always_comb begin
        unique case (PADDR_I)
            apub_pkg::OFS_AXIS_SEL,
            apub_pkg::OFS_CMD,
            apub_pkg::OFS_THR_PEND,
            apub_pkg::OFS_THR_ACT,
            apub_pkg::OFS_AXIS_MODE,
            apub_pkg::OFS_VEL_PEND,
            apub_pkg::OFS_VEL_ACT,
            apub_pkg::OFS_IRQ_STAT,
            apub_pkg::OFS_IRQ_MASK: addr_ok = 1'b1;
            default:                addr_ok = 1'b0;
        endcase
    end

    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
    assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I & addr_ok;
    assign rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign sel_cur   = N'(1) << axis_r;

    // Write strobes per register
    logic                              wr_cmd;
    logic                              wr_thr;
    logic                              wr_vel;
    logic [apub_pkg::CMD_CODE_W-1:0]   cmd_code;
    logic [N-1:0]                      cmd_mask;

    assign wr_cmd   = wr_en & (PADDR_I == apub_pkg::OFS_CMD);
    assign wr_thr   = wr_en & (PADDR_I == apub_pkg::OFS_THR_PEND);
    assign wr_vel   = wr_en & (PADDR_I == apub_pkg::OFS_VEL_PEND);
    assign cmd_code = PWDATA_I[apub_pkg::CMD_CODE_LSB +: apub_pkg::CMD_CODE_W];
    assign cmd_mask = PWDATA_I[apub_pkg::CMD_MASK_LSB +: N];

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            axis_r <= '0;
        end else if (wr_en && PADDR_I == apub_pkg::OFS_AXIS_SEL) begin
            axis_r <= PWDATA_I[apub_pkg::AXW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Home flags pass two flip-flops

    logic [2*N-1:0] home_a_r;
    logic [2*N-1:0] home_b_r;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            home_a_r <= '0;
            home_b_r <= '0;
        end else begin
            home_a_r <= {HOME_CAPT_I, HOME_REQ_I};
            home_b_r <= home_a_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-axis pending and active state

    logic [apub_pkg::DW-1:0] thr_pend_w [N];
    logic [apub_pkg::DW-1:0] thr_act_w  [N];
    logic [apub_pkg::DW-1:0] vel_pend_w [N];
    logic [apub_pkg::DW-1:0] vel_act_w  [N];
    logic [5:0]              mode_w     [N];
    logic [N-1:0]            fire_w;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_axis
            logic [apub_pkg::DW-1:0] thr_pend_r;
            logic [apub_pkg::DW-1:0] thr_act_r;
            logic [apub_pkg::DW-1:0] vel_pend_r;
            logic [apub_pkg::DW-1:0] vel_act_r;
            logic                    halt_pend_r;
            logic                    halt_act_r;
            logic                    auto_r;
            logic                    commit_r;
            logic                    fired_r;
            apub_pkg::apub_brk_t     brk_r;
            logic                    cmd_here;
            logic                    cond;
            logic                    fire;
            logic signed [31:0]      pos;

            assign cmd_here = wr_cmd & sel_cur[g];
            assign pos      = POS_ACT_I[g*32 +: 32];

            // Pending values, written for the current axis only
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    thr_pend_r <= apub_pkg::RST_WORD;
                    vel_pend_r <= apub_pkg::RST_WORD;
                end else begin
                    if (wr_thr && sel_cur[g]) begin
                        thr_pend_r <= PWDATA_I;
                    end
                    if (wr_vel && sel_cur[g]) begin
                        vel_pend_r <= PWDATA_I;
                    end
                end
            end

            // Smooth halt waits in the pending buffer
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    halt_pend_r <= 1'b0;
                end else if (cmd_here && cmd_code == apub_pkg::CMD_SMOOTH_HALT) begin
                    halt_pend_r <= 1'b1; // [RULE15]
                end else if (tick_r && commit_r) begin
                    halt_pend_r <= 1'b0;
                end
            end

            // Auto commit enable
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    auto_r <= 1'b0; // [RULE3]
                end else if (cmd_here && cmd_code == apub_pkg::CMD_AUTO_ON) begin
                    auto_r <= 1'b1; // [RULE3]
                end else if (cmd_here && cmd_code == apub_pkg::CMD_AUTO_OFF) begin
                    auto_r <= 1'b0; // [RULE3]
                end
            end

            // Breakpoint condition, sampled once per tick
            always_comb begin
                unique case (brk_r)
                    apub_pkg::BRK_RISE: cond = pos >= $signed(thr_act_r); // [RULE8]
                    apub_pkg::BRK_FALL: cond = pos <= $signed(thr_act_r); // [RULE9]
                    apub_pkg::BRK_DONE: cond = MOTION_DONE_I[g]; // [RULE12]
                    apub_pkg::BRK_HOME: cond = home_b_r[g] & home_b_r[N+g]; // [RULE16]
                    default:            cond = 1'b0;
                endcase
            end

            assign fire = tick_r & cond; // [RULE18]

            // Arming state; a fire disarms before a new command arms
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    brk_r <= apub_pkg::BRK_IDLE;
                end else if (cmd_here) begin
                    unique case (cmd_code)
                        apub_pkg::CMD_ARM_RISE: brk_r <= apub_pkg::BRK_RISE; // [RULE7]
                        apub_pkg::CMD_ARM_FALL: brk_r <= apub_pkg::BRK_FALL; // [RULE7]
                        apub_pkg::CMD_ARM_DONE: brk_r <= apub_pkg::BRK_DONE; // [RULE7]
                        apub_pkg::CMD_ARM_HOME: brk_r <= apub_pkg::BRK_HOME; // [RULE7]
                        apub_pkg::CMD_DISARM:   brk_r <= apub_pkg::BRK_IDLE; // [RULE6]
                        default:                brk_r <= fire ? apub_pkg::BRK_IDLE : brk_r;
                    endcase
                end else if (fire) begin
                    brk_r <= apub_pkg::BRK_IDLE; // [RULE5] [RULE13]
                end
            end

            // Commit request, served at the next tick
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    commit_r <= 1'b0;
                end else begin
                    commit_r <= (commit_r & ~tick_r)
                              | (cmd_here && cmd_code == apub_pkg::CMD_COMMIT_CUR) // [RULE1]
                              | (wr_cmd && cmd_code == apub_pkg::CMD_COMMIT_MASK
                                 && cmd_mask[g]) // [RULE2]
                              | (fire & auto_r); // [RULE13]
                end
            end

            // All pending values become active on one tick
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    thr_act_r <= apub_pkg::RST_WORD;
                    vel_act_r <= apub_pkg::RST_WORD;
                end else if (tick_r && commit_r) begin
                    thr_act_r <= thr_pend_r; // [RULE17]
                    vel_act_r <= vel_pend_r; // [RULE17]
                end
            end

            // Active halt holds until the axis reports motion done
            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    halt_act_r <= 1'b0;
                end else if (tick_r && commit_r && halt_pend_r) begin
                    halt_act_r <= 1'b1; // [RULE15] [RULE17]
                end else if (MOTION_DONE_I[g]) begin
                    halt_act_r <= 1'b0;
                end
            end

            always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    fired_r <= 1'b0;
                end else begin
                    fired_r <= fire;
                end
            end

            assign thr_pend_w[g]       = thr_pend_r;
            assign thr_act_w[g]        = thr_act_r;
            assign vel_pend_w[g]       = vel_pend_r;
            assign vel_act_w[g]        = vel_act_r;
            assign mode_w[g]           = {brk_r, auto_r}; // [RULE4]
            assign fire_w[g]           = fire;
            assign VEL_ACT_O[g*32 +: 32] = vel_act_r;
            assign SMOOTH_HALT_O[g]    = halt_act_r;
            assign BRK_FIRED_O[g]      = fired_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Breakpoint-triggered flags and interrupt

    logic [N-1:0] irq_stat_r;
    logic [N-1:0] irq_mask_r;
    logic [N-1:0] stat_clr;

    assign stat_clr = (wr_en && PADDR_I == apub_pkg::OFS_IRQ_STAT) ? PWDATA_I[N-1:0] : '0;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_stat_r <= apub_pkg::RST_MASK;
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr) | fire_w; // [RULE14]
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_mask_r <= apub_pkg::RST_MASK;
        end else if (wr_en && PADDR_I == apub_pkg::OFS_IRQ_MASK) begin
            irq_mask_r <= PWDATA_I[N-1:0];
        end
    end

    assign IRQ_O = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    logic [apub_pkg::DW-1:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        unique case (PADDR_I)
            apub_pkg::OFS_AXIS_SEL:  rd_nxt[apub_pkg::AXW-1:0] = axis_r;
            apub_pkg::OFS_THR_PEND:  rd_nxt = thr_pend_w[axis_r];
            apub_pkg::OFS_THR_ACT:   rd_nxt = thr_act_w[axis_r]; // [RULE11]
            apub_pkg::OFS_AXIS_MODE: rd_nxt[5:0] = mode_w[axis_r]; // [RULE4]
            apub_pkg::OFS_VEL_PEND:  rd_nxt = vel_pend_w[axis_r];
            apub_pkg::OFS_VEL_ACT:   rd_nxt = vel_act_w[axis_r];
            apub_pkg::OFS_IRQ_STAT:  rd_nxt[N-1:0] = irq_stat_r;
            apub_pkg::OFS_IRQ_MASK:  rd_nxt[N-1:0] = irq_mask_r;
            default:                 rd_nxt = '0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRDATA_O <= apub_pkg::RST_WORD;
        end else if (rd_setup) begin
            PRDATA_O <= rd_nxt;
        end
    end

endmodule

//--- inc/apub_pkg.sv
package apub_pkg;

    // Axis count and data widths
    localparam int NUM_AXES = 4;
    localparam int AXW      = 2;
    localparam int DW       = 32;
    localparam int AW       = 8;

    // Sample period pacing
    localparam int CLK_PERIOD_NS    = 40;
    localparam int SAMPLE_PERIOD_NS = 100000;
    localparam int SAMPLE_CYC       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SCW              = 12;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_AXIS_SEL   = 8'h00;
    localparam logic [AW-1:0] OFS_CMD        = 8'h04;
    localparam logic [AW-1:0] OFS_THR_PEND   = 8'h08;
    localparam logic [AW-1:0] OFS_THR_ACT    = 8'h0c;
    localparam logic [AW-1:0] OFS_AXIS_MODE  = 8'h10;
    localparam logic [AW-1:0] OFS_VEL_PEND   = 8'h14;
    localparam logic [AW-1:0] OFS_VEL_ACT    = 8'h18;
    localparam logic [AW-1:0] OFS_IRQ_STAT   = 8'h1c;
    localparam logic [AW-1:0] OFS_IRQ_MASK   = 8'h20;

    // Command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CODE_W   = 4;
    localparam int CMD_MASK_LSB = 8;

    // Command codes
    localparam logic [CMD_CODE_W-1:0] CMD_COMMIT_CUR  = 4'h1;
    localparam logic [CMD_CODE_W-1:0] CMD_COMMIT_MASK = 4'h2;
    localparam logic [CMD_CODE_W-1:0] CMD_AUTO_ON     = 4'h3;
    localparam logic [CMD_CODE_W-1:0] CMD_AUTO_OFF    = 4'h4;
    localparam logic [CMD_CODE_W-1:0] CMD_ARM_RISE    = 4'h5;
    localparam logic [CMD_CODE_W-1:0] CMD_ARM_FALL    = 4'h6;
    localparam logic [CMD_CODE_W-1:0] CMD_ARM_DONE    = 4'h7;
    localparam logic [CMD_CODE_W-1:0] CMD_ARM_HOME    = 4'h8;
    localparam logic [CMD_CODE_W-1:0] CMD_DISARM      = 4'h9;
    localparam logic [CMD_CODE_W-1:0] CMD_SMOOTH_HALT = 4'ha;

    // Mode register fields
    localparam int MODE_AUTO_BIT = 0;
    localparam int MODE_ARM_LSB  = 1;

    // Reset values
    localparam logic [DW-1:0]       RST_WORD = 32'h0000_0000;
    localparam logic [NUM_AXES-1:0] RST_MASK = 4'h0;

    // Breakpoint arming state
    typedef enum logic [4:0] {
        BRK_IDLE = 5'b00001,
        BRK_RISE = 5'b00010,
        BRK_FALL = 5'b00100,
        BRK_DONE = 5'b01000,
        BRK_HOME = 5'b10000
    } apub_brk_t;

endpackage

//--- testbench/apub_axis_model.sv
module apub_axis_model #(
    parameter logic signed [31:0] HOME_POS = 32'sh0000_0000
) (
    input  wire logic                               clk_i,
    input  wire logic                               nrst_i,
    input  wire logic                               tick_i,
    input  wire logic [apub_pkg::NUM_AXES*32-1:0]   vel_i,
    input  wire logic [apub_pkg::NUM_AXES-1:0]      home_req_i,
    output logic      [apub_pkg::NUM_AXES*32-1:0]   pos_o,
    output logic      [apub_pkg::NUM_AXES-1:0]      done_o,
    output logic      [apub_pkg::NUM_AXES-1:0]      req_o,
    output logic      [apub_pkg::NUM_AXES-1:0]      capt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Position moves by the active velocity once per sample period
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_o <= '0;
        end else if (tick_i) begin
            for (int g = 0; g < apub_pkg::NUM_AXES; g++) begin
                pos_o[g*32+:32] <= pos_o[g*32+:32] + vel_i[g*32+:32];
            end
        end
    end
    always_comb begin
        for (int g = 0; g < apub_pkg::NUM_AXES; g++) begin
            done_o[g] = (vel_i[g*32+:32] == 32'h0);
            capt_o[g] = home_req_i[g] && ($signed(pos_o[g*32+:32]) >= HOME_POS);
        end
    end
    assign req_o = home_req_i;
endmodule

//--- testbench/apub_chk.sv
module apub_chk (
    input wire logic                               CORE_CLK_I,
    input wire logic                               NRST_I,
    input wire logic                               PSEL_I,
    input wire logic                               PENABLE_I,
    input wire logic                               PWRITE_I,
    input wire logic [apub_pkg::AW-1:0]            PADDR_I,
    input wire logic [apub_pkg::DW-1:0]            PRDATA_O,
    input wire logic                               PREADY_O,
    input wire logic                               PSLVERR_O,
    input wire logic [apub_pkg::NUM_AXES*32-1:0]   VEL_ACT_O,
    input wire logic [apub_pkg::NUM_AXES-1:0]      SMOOTH_HALT_O,
    input wire logic [apub_pkg::NUM_AXES-1:0]      BRK_FIRED_O,
    input wire logic                               SAMPLE_TICK_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        acc;
    logic [11:0] gap_r;
    assign acc = PSEL_I && PENABLE_I;
    // Edges since the last tick, one at the tick edge itself
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            gap_r <= 12'h000;
        end else begin
            gap_r <= SAMPLE_TICK_O ? 12'h001 : gap_r + 12'h001;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    AST_READY: assert property (acc |-> PREADY_O) else $error("access without ready");
    AST_UNMAPPED: assert property (acc && PADDR_I > apub_pkg::OFS_IRQ_MASK |-> PSLVERR_O)
        else $error("unmapped access without error");
    AST_MAPPED: assert property (acc && PADDR_I[1:0] == 2'h0
        && PADDR_I <= apub_pkg::OFS_IRQ_MASK |-> !PSLVERR_O) else $error("mapped access error");
    AST_CMD_READS_ZERO: assert property (acc && !PWRITE_I && PADDR_I == apub_pkg::OFS_CMD
        |-> PRDATA_O == 32'h0) else $error("command word read nonzero");
    AST_TICK_GAP: assert property (SAMPLE_TICK_O
        |-> gap_r == 12'(apub_pkg::SAMPLE_CYC)) else $error("tick spacing wrong");
    AST_TICK_LATE: assert property (gap_r <= 12'(apub_pkg::SAMPLE_CYC))
        else $error("tick missing");
    AST_TICK_PULSE: assert property (SAMPLE_TICK_O |=> !SAMPLE_TICK_O) else $error("tick too long");
    AST_FIRE_ON_TICK: assert property (|BRK_FIRED_O |-> $past(SAMPLE_TICK_O))
        else $error("fire outside tick");
    AST_FIRE_PULSE: assert property (|BRK_FIRED_O |=> BRK_FIRED_O == 4'h0)
        else $error("fire pulse too long");
    AST_VEL_ON_TICK: assert property (!$stable(VEL_ACT_O) |-> $past(SAMPLE_TICK_O))
        else $error("velocity changed off tick");
    AST_HALT_ON_TICK: assert property (|(SMOOTH_HALT_O & ~$past(SMOOTH_HALT_O))
        |-> $past(SAMPLE_TICK_O)) else $error("halt rose off tick");
    cover property (|BRK_FIRED_O);
    cover property (acc && PSLVERR_O);
    cover property (|SMOOTH_HALT_O);
endmodule
bind apub_top apub_chk i_chk (.CORE_CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .VEL_ACT_O, .SMOOTH_HALT_O, .BRK_FIRED_O, .SAMPLE_TICK_O);

//--- testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, nrst, psel, penable, pwrite, pready, pslverr, tick, irq, er, s;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [127:0]       pos, vel;
    logic [3:0]         done, hreq_in, hreq, capt, halt, fired;
    logic signed [31:0] thr;
    int                 mismatches, comparisons, cycles;
    apub_top i_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .POS_ACT_I(pos), .MOTION_DONE_I(done),
        .HOME_REQ_I(hreq), .HOME_CAPT_I(capt), .VEL_ACT_O(vel), .SMOOTH_HALT_O(halt),
        .BRK_FIRED_O(fired), .SAMPLE_TICK_O(tick), .IRQ_O(irq));
    apub_axis_model i_axes (.clk_i(clk), .nrst_i(nrst), .tick_i(tick), .vel_i(vel),
        .home_req_i(hreq_in), .pos_o(pos), .done_o(done), .req_o(hreq), .capt_o(capt));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task automatic wait_tick(input int n);
        repeat (n) begin
            @(posedge clk);
            while (tick !== 1'b1) @(posedge clk);
        end
        @(posedge clk);
    endtask
    task automatic wait_fire(input int ax, input int nt);
        repeat (nt * apub_pkg::SAMPLE_CYC + 2) begin
            @(posedge clk);
            if (fired[ax] === 1'b1) break;
        end
        s = (fired[ax] === 1'b1);
    endtask
    task automatic t_reset();
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h2, "mode at reset");
        rdchk(apub_pkg::OFS_THR_ACT, 32'h0, "threshold at reset");
        rdchk(apub_pkg::OFS_CMD, 32'h0, "command read");
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("reset test done");
    endtask
    task automatic t_commit();
        apb(1'b1, apub_pkg::OFS_VEL_PEND, 32'h5);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_SMOOTH_HALT));
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_COMMIT_CUR));
        chk(vel[31:0], 32'h0, "velocity before tick");
        chk(halt[0], 1'b0, "halt before commit");
        wait_tick(1);
        chk(vel[31:0], 32'h5, "committed velocity");
        chk(halt[0], 1'b1, "committed halt");
        $display("commit test done");
    endtask
    task automatic t_mask();
        for (int a = 1; a < 4; a++) begin
            apb(1'b1, apub_pkg::OFS_AXIS_SEL, 32'(a));
            apb(1'b1, apub_pkg::OFS_VEL_PEND, 32'(a + 1) ^ 32'h1);
        end
        apb(1'b1, apub_pkg::OFS_CMD, (32'h6 << apub_pkg::CMD_MASK_LSB)
            | 32'(apub_pkg::CMD_COMMIT_MASK));
        chk(vel[63:32], 32'h0, "masked before tick");
        wait_tick(1);
        chk(vel[63:32], 32'h3, "axis1 velocity");
        chk(vel[95:64], 32'h2, "axis2 velocity");
        chk(vel[127:96], 32'h0, "axis3 untouched");
        $display("masked commit test done");
    endtask
    task automatic t_rise();
        wait_tick(1);
        thr = $signed(pos[63:32]) + 32'sd9;
        apb(1'b1, apub_pkg::OFS_AXIS_SEL, 32'h1);
        apb(1'b1, apub_pkg::OFS_THR_PEND, thr);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_COMMIT_CUR));
        wait_tick(1);
        rdchk(apub_pkg::OFS_THR_ACT, thr, "held threshold");
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_AUTO_ON));
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h3, "auto on");
        apb(1'b1, apub_pkg::OFS_VEL_PEND, 32'h7);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_ARM_RISE));
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h5, "rise armed");
        wait_fire(1, 4);
        chk(s, 1'b1, "rise fired");
        chk($signed(pos[63:32]) - 32'sd3 >= thr, 1'b1, "fired late check");
        chk($signed(pos[63:32]) - 32'sd6 < thr, 1'b1, "fired early check");
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h3, "disarmed");
        rdchk(apub_pkg::OFS_IRQ_STAT, 32'h2, "triggered flag");
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, apub_pkg::OFS_IRQ_MASK, 32'h2);
        chk(irq, 1'b1, "irq unmasked");
        apb(1'b1, apub_pkg::OFS_IRQ_STAT, 32'h2);
        chk(irq, 1'b0, "irq cleared");
        wait_tick(1);
        chk(vel[63:32], 32'h7, "auto commit");
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_AUTO_OFF));
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h2, "auto off");
        $display("rising break test done");
    endtask
    task automatic t_fall();
        wait_tick(1);
        thr = $signed(pos[95:64]) + 32'sd2;
        apb(1'b1, apub_pkg::OFS_AXIS_SEL, 32'h2);
        apb(1'b1, apub_pkg::OFS_THR_PEND, thr);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_COMMIT_CUR));
        wait_tick(1);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_ARM_FALL));
        apb(1'b1, apub_pkg::OFS_VEL_PEND, 32'h9);
        wait_fire(2, 2);
        chk(s, 1'b1, "fall fired at equal");
        rdchk(apub_pkg::OFS_IRQ_STAT, 32'h4, "triggered no auto");
        wait_tick(1);
        chk(vel[95:64], 32'h2, "no auto commit");
        $display("falling break test done");
    endtask
    task automatic t_axis3();
        wait_tick(1);
        apb(1'b1, apub_pkg::OFS_AXIS_SEL, 32'h3);
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_ARM_DONE));
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_DISARM));
        wait_fire(3, 2);
        chk(s, 1'b0, "disarmed no fire");
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_ARM_DONE));
        wait_fire(3, 2);
        chk(s, 1'b1, "done fired");
        rdchk(apub_pkg::OFS_AXIS_MODE, 32'h2, "done disarmed");
        wait_fire(3, 2);
        chk(s, 1'b0, "single trigger");
        apb(1'b1, apub_pkg::OFS_CMD, 32'(apub_pkg::CMD_ARM_HOME));
        wait_fire(3, 2);
        chk(s, 1'b0, "home not requested");
        hreq_in <= 4'h8;
        wait_fire(3, 2);
        chk(s, 1'b1, "home fired");
        $display("axis3 break test done");
    endtask
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hreq_in = 4'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_commit();
        t_mask();
        t_rise();
        t_fall();
        t_axis3();
        test_done();
    end
endmodule
